// ==== rtl/temp_monitor_pkg.sv ====
package temp_monitor_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NCH    = 5;
    localparam int RAW_W  = 12;
    localparam int CODE_W = 11;

    // Link slave address, plain default
    localparam logic [6:0] DEV_ADDR = 7'h4c;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_STATUS     = 8'h02;
    localparam logic [7:0] ADR_CONFIG     = 8'h03;
    localparam logic [7:0] ADR_CONFIG_ALT = 8'h09;
    localparam logic [7:0] ADR_ONESHOT    = 8'h0f;
    localparam logic [7:0] ADR_HI0_A      = 8'h05;
    localparam logic [7:0] ADR_HI0_B      = 8'h0b;
    localparam logic [7:0] ADR_LO0_A      = 8'h06;
    localparam logic [7:0] ADR_LO0_B      = 8'h0c;
    localparam logic [7:0] ADR_HYST       = 8'h21;
    localparam logic [7:0] ADR_HISTAT     = 8'h35;
    localparam logic [7:0] ADR_LOSTAT     = 8'h36;
    localparam logic [7:0] ADR_CRITSTAT   = 8'h37;
    localparam logic [7:0] ADR_TEMP_BASE  = 8'h60;
    localparam logic [7:0] ADR_HI_BASE    = 8'h70;
    localparam logic [7:0] ADR_LO_BASE    = 8'h78;
    localparam logic [7:0] ADR_CRIT_BASE  = 8'h80;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_MASK  = 7;
    localparam int CFG_STOP  = 6;
    localparam int CFG_RANGE = 2;
    localparam int ST_HIGH   = 4;
    localparam int ST_LOW    = 3;
    localparam int ST_CRIT   = 1;

    // ----------------------------------------------------------------
    // Reset values and code limits
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [7:0] RST_HI_LIM   = 8'h55;
    localparam logic [7:0] RST_LO_LIM   = 8'h00;
    localparam logic [7:0] RST_CRIT_LIM = 8'h64;
    localparam logic [7:0] RST_HYST     = 8'h0a;
    localparam logic [CODE_W-1:0] CODE_MAX = 11'h7ff;
    localparam logic [CODE_W-1:0] DEF_MAX  = 11'h3ff;
    localparam logic signed [RAW_W:0] EXT_OFFSET = 13'sh0200;

    // Link slave states
    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_PTR,
        L_DATA_ACK, L_WDATA, L_RDATA, L_RACK
    } link_e;

endpackage : temp_monitor_pkg

// ==== rtl/temp_result_format_limit_compare.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - Result is 11 bits: high byte, low top three
// - Default range: unsigned, 0.125 degree steps to 127.875
// - Extended range: offset by 64 degrees
// - Default range clamps to zero and 127.875
// - Extended range clamps to minus 64 and 191.875
// - New result compared with its high, low limits
// - Each channel has own high, low, critical limits
// - Result above high limit sets status and warning
// - Result at or below low sets status, warning
// - Warning output can be masked by configuration
// - Result at or above critical asserts critical, unmasked
// - Aliased limit registers behave identically at each address
// - Standby limit writes act after next conversion
// - One-shot write or clearing stop starts conversion
// - One internal plus four external channels
// - High status read clears bits and summary flag
// - Critical releases below limit minus hysteresis
module temp_result_format_limit_compare
    import temp_monitor_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire logic                    sclIn,
    input  wire logic                    sdaIn,
    output logic                         sdaOut,
    output logic                         sdaOe,
    input  wire logic                    convDone,
    input  wire logic [2:0]              convCh,
    input  wire logic signed [RAW_W-1:0] convRaw,
    output logic                         convStart,
    output logic                         standby,
    output logic                         warnOe,
    output logic                         critOe
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        link_e                       st;
        logic [2:0]                  sclSync;
        logic [2:0]                  sdaSync;
        logic [3:0]                  cnt;
        logic [7:0]                  shift;
        logic [7:0]                  tx;
        logic [7:0]                  ptr;
        logic                        sdaOe;
        logic                        sdaOut;
        logic [7:0]                  deviceConfiguration;
        logic [7:0]                  hyst;
        logic [NCH-1:0][7:0]         hiLim;
        logic [NCH-1:0][7:0]         loLim;
        logic [NCH-1:0][7:0]         critLim;
        logic [NCH-1:0][CODE_W-1:0]  temp;
        logic [NCH-1:0]              hiStat;
        logic [NCH-1:0]              loStat;
        logic [NCH-1:0]              critOn;
        logic                        warnOe;
        logic                        critOe;
        logic                        convStart;
    } state_s;

    state_s s;
    state_s next_s;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Raw signed eighths of a degree to an 11-bit result code
    function automatic logic [CODE_W-1:0] fmtTemp(
        input logic signed [RAW_W-1:0] raw,
        input logic                    ext
    );
        logic signed [RAW_W:0] v;
        logic [CODE_W-1:0]     top;
        top = ext ? CODE_MAX : DEF_MAX;
        v   = {raw[RAW_W-1], raw};
        if (ext) begin
            v = v + EXT_OFFSET;
        end
        if (v < 13'sh0000) begin
            fmtTemp = '0;
        end else if (v > $signed({2'b00, top})) begin
            fmtTemp = top;
        end else begin
            fmtTemp = v[CODE_W-1:0];
        end
    endfunction : fmtTemp

    // Limit byte scaled onto the result code grid
    function automatic logic [CODE_W:0] limCode(input logic [7:0] lim);
        limCode = {1'b0, lim, 3'b000};
    endfunction : limCode

    // Folds alias addresses onto one register
    function automatic logic [7:0] canon(input logic [7:0] a);
        unique case (a)
            ADR_HI0_A, ADR_HI0_B: canon = ADR_HI_BASE;
            ADR_LO0_A, ADR_LO0_B: canon = ADR_LO_BASE;
            ADR_CONFIG_ALT:       canon = ADR_CONFIG;
            default:              canon = a;
        endcase
    endfunction : canon

    // Register read data for a canonical address
    function automatic logic [7:0] readReg(
        input logic [7:0] a,
        input state_s     r
    );
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            ADR_STATUS: begin
                d[ST_HIGH] = |r.hiStat;
                d[ST_LOW]  = |r.loStat;
                d[ST_CRIT] = |r.critOn;
            end
            ADR_CONFIG:   d = r.deviceConfiguration;
            ADR_HYST:     d = r.hyst;
            ADR_HISTAT:   d = {3'b000, r.hiStat};
            ADR_LOSTAT:   d = {3'b000, r.loStat};
            ADR_CRITSTAT: d = {3'b000, r.critOn};
            default:      d = 8'h00;
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (a == 8'(ADR_HI_BASE + i)) begin
                d = r.hiLim[i];
            end
            if (a == 8'(ADR_LO_BASE + i)) begin
                d = r.loLim[i];
            end
            if (a == 8'(ADR_CRIT_BASE + i)) begin
                d = r.critLim[i];
            end
            if (a == 8'(ADR_TEMP_BASE + 2 * i)) begin
                d = r.temp[i][CODE_W-1:3];
            end
            if (a == 8'(ADR_TEMP_BASE + 2 * i + 1)) begin
                d = {r.temp[i][2:0], 5'b00000};
            end
        end
        readReg = d;
    endfunction : readReg

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    // Link slave, register access, conversion compare and pins
    always_comb begin
        logic             sclRise;
        logic             sclFall;
        logic             startC;
        logic             stopC;
        logic             sdaBit;
        logic             wr;
        logic             rd;
        logic [7:0]       a;
        logic [7:0]       wd;
        logic [7:0]       rdata;
        logic [NCH-1:0]   setHi;
        logic [NCH-1:0]   setLo;
        logic [CODE_W-1:0] code;
        logic signed [CODE_W+1:0] relTh;
        next_s    = s;
        sclRise   = s.sclSync[1] & ~s.sclSync[2];
        sclFall   = ~s.sclSync[1] & s.sclSync[2];
        startC    = s.sclSync[1] & s.sclSync[2]
                    & ~s.sdaSync[1] & s.sdaSync[2];
        stopC     = s.sclSync[1] & s.sclSync[2]
                    & s.sdaSync[1] & ~s.sdaSync[2];
        sdaBit    = s.sdaSync[1];
        wr        = 1'b0;
        rd        = 1'b0;
        a         = canon(s.ptr);
        wd        = s.shift;
        rdata     = readReg(a, s);
        setHi     = '0;
        setLo     = '0;
        code      = '0;
        relTh     = '0;
        next_s.convStart = 1'b0;
        next_s.sdaOut    = 1'b0;

        // Two-stage synchronisers plus one stage for edges
        next_s.sclSync = {s.sclSync[1:0], sclIn};
        next_s.sdaSync = {s.sdaSync[1:0], sdaIn};

        // Receive shift on rising clock edges
        if (sclRise && (s.st == L_ADDR || s.st == L_PTR
                        || s.st == L_WDATA)) begin
            next_s.shift = {s.shift[6:0], sdaBit};
            next_s.cnt   = s.cnt + 4'h1;
        end

        // Byte level sequencing on falling clock edges
        if (sclFall) begin
            unique case (s.st)
                L_IDLE:     next_s.sdaOe = 1'b0;
                L_ADDR: begin
                    if (s.cnt == 4'h8) begin
                        next_s.cnt = 4'h0;
                        if (s.shift[7:1] == DEV_ADDR) begin
                            next_s.sdaOe = 1'b1;
                            next_s.st    = L_ADDR_ACK;
                        end else begin
                            next_s.st = L_IDLE;
                        end
                    end
                end
                L_ADDR_ACK: begin
                    if (s.shift[0]) begin
                        rd            = 1'b1;
                        next_s.tx     = {rdata[6:0], 1'b0};
                        next_s.sdaOe  = ~rdata[7];
                        next_s.cnt    = 4'h1;
                        next_s.st     = L_RDATA;
                    end else begin
                        next_s.sdaOe = 1'b0;
                        next_s.st    = L_PTR;
                    end
                end
                L_PTR: begin
                    if (s.cnt == 4'h8) begin
                        next_s.ptr   = s.shift;
                        next_s.cnt   = 4'h0;
                        next_s.sdaOe = 1'b1;
                        next_s.st    = L_DATA_ACK;
                    end
                end
                L_DATA_ACK: begin
                    next_s.sdaOe = 1'b0;
                    next_s.st    = L_WDATA;
                end
                L_WDATA: begin
                    if (s.cnt == 4'h8) begin
                        wr           = 1'b1;
                        next_s.cnt   = 4'h0;
                        next_s.sdaOe = 1'b1;
                        next_s.st    = L_DATA_ACK;
                    end
                end
                L_RDATA: begin
                    if (s.cnt == 4'h8) begin
                        next_s.sdaOe = 1'b0;
                        next_s.st    = L_RACK;
                    end else begin
                        next_s.sdaOe = ~s.tx[7];
                        next_s.tx    = {s.tx[6:0], 1'b0};
                        next_s.cnt   = s.cnt + 4'h1;
                    end
                end
                L_RACK: begin
                    rd            = 1'b1;
                    next_s.tx     = {rdata[6:0], 1'b0};
                    next_s.sdaOe  = ~rdata[7];
                    next_s.cnt    = 4'h1;
                    next_s.st     = L_RDATA;
                end
            endcase
        end

        // A master NACK ends the read burst
        if (sclRise && s.st == L_RACK && sdaBit) begin
            next_s.st = L_IDLE;
        end

        // Start and stop override any byte in progress
        if (startC) begin
            next_s.st    = L_ADDR;
            next_s.cnt   = 4'h0;
            next_s.sdaOe = 1'b0;
        end else if (stopC) begin
            next_s.st    = L_IDLE;
            next_s.sdaOe = 1'b0;
        end

        // Register writes
        if (wr) begin
            if (a == ADR_CONFIG) begin
                next_s.deviceConfiguration = wd;
                if (s.deviceConfiguration[CFG_STOP] && !wd[CFG_STOP]) begin
                    next_s.convStart = 1'b1;
                end
            end
            if (a == ADR_ONESHOT) begin
                next_s.convStart = 1'b1;
            end
            if (a == ADR_HYST) begin
                next_s.hyst = wd;
            end
            for (int i = 0; i < NCH; i++) begin
                if (a == 8'(ADR_HI_BASE + i)) begin
                    next_s.hiLim[i] = wd;
                end
                if (a == 8'(ADR_LO_BASE + i)) begin
                    next_s.loLim[i] = wd;
                end
                if (a == 8'(ADR_CRIT_BASE + i)) begin
                    next_s.critLim[i] = wd;
                end
            end
        end

        // Store a finished conversion and compare it
        if (convDone && convCh < 3'(NCH)) begin
            code = fmtTemp(convRaw, s.deviceConfiguration[CFG_RANGE]);
            next_s.temp[convCh] = code;
            if ({1'b0, code} > limCode(s.hiLim[convCh])) begin
                setHi[convCh] = 1'b1;
            end
            if ({1'b0, code} <= limCode(s.loLim[convCh])) begin
                setLo[convCh] = 1'b1;
            end
            relTh = $signed({1'b0, limCode(s.critLim[convCh])})
                    - $signed({1'b0, limCode(s.hyst)});
            if ({1'b0, code} >= limCode(s.critLim[convCh])) begin
                next_s.critOn[convCh] = 1'b1;
            end else if ($signed({2'b00, code}) < relTh) begin
                next_s.critOn[convCh] = 1'b0;
            end
        end

        // Sticky status: read clears, a same-cycle set wins
        next_s.hiStat = (rd && a == ADR_HISTAT) ? setHi
                        : s.hiStat | setHi;
        next_s.loStat = (rd && a == ADR_LOSTAT) ? setLo : s.loStat | setLo;

        // Pin drive, warning masked, critical never masked
        next_s.warnOe = ~s.deviceConfiguration[CFG_MASK]
                        & (|next_s.hiStat | |next_s.loStat);
        next_s.critOe = |next_s.critOn;
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------

    // State register with synchronous reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s           <= '0;
            s.st        <= L_IDLE;
            s.sclSync   <= 3'h7;
            s.sdaSync   <= 3'h7;
            s.deviceConfiguration <= RST_CONFIG;
            s.hyst      <= RST_HYST;
            s.hiLim     <= {NCH{RST_HI_LIM}};
            s.loLim     <= {NCH{RST_LO_LIM}};
            s.critLim   <= {NCH{RST_CRIT_LIM}};
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from flip-flops
    assign sdaOut    = s.sdaOut;
    assign sdaOe     = s.sdaOe;
    assign convStart = s.convStart;
    assign standby   = s.deviceConfiguration[CFG_STOP];
    assign warnOe    = s.warnOe;
    assign critOe    = s.critOe;

endmodule : temp_result_format_limit_compare

// ==== tb/temp_monitor_asserts.sv ====
`timescale 1ns/100ps
module temp_monitor_asserts
    import temp_monitor_pkg::*;
(
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire logic                    sclIn,
    input wire logic                    sdaIn,
    input wire logic                    sdaOut,
    input wire logic                    sdaOe,
    input wire logic                    convDone,
    input wire logic [2:0]              convCh,
    input wire logic signed [RAW_W-1:0] convRaw,
    input wire logic                    convStart,
    input wire logic                    standby,
    input wire logic                    warnOe,
    input wire logic                    critOe
);
    // ----------------------------------------------------------------
    // Output timing against conversions, config and link
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_crit_rise: assert property (
        $rose(critOe) |-> $past(convDone && convCh < 3'h5))
        else $error("critical raised without a conversion");
    a_crit_fall: assert property (
        $fell(critOe) |-> $past(convDone))
        else $error("critical released without a conversion");
    a_crit_hold: assert property (
        !(convDone && convCh < 3'h5) |=> $stable(critOe))
        else $error("critical moved with no valid conversion");
    a_start_pulse: assert property (
        convStart |=> !convStart)
        else $error("start pulse longer than one cycle");
    a_standby_start: assert property (
        $fell(standby) |-> ##[0:1] convStart)
        else $error("leaving standby gave no start");
    a_standby_nostart: assert property (
        $rose(standby) |-> !convStart)
        else $error("entering standby started a conversion");
    a_reset_quiet: assert property (
        $fell(rst) |-> !warnOe && !critOe && !convStart && !standby)
        else $error("outputs active after reset");
    a_link_timing: assert property (
        $changed(sdaOe) |-> !sclIn && !$past(sclIn, 3))
        else $error("data pin changed outside clock low");

    c_crit: cover property ($rose(critOe));
    c_warn: cover property ($rose(warnOe));
    c_start: cover property (convStart);
endmodule : temp_monitor_asserts

bind temp_result_format_limit_compare temp_monitor_asserts
    temp_monitor_asserts_i (.ref_clk, .rst, .sclIn, .sdaIn, .sdaOut,
    .sdaOe, .convDone, .convCh, .convRaw, .convStart, .standby,
    .warnOe, .critOe);

// ==== tb/i2c_host_model.sv ====
`timescale 1ns/100ps
module i2c_host_model
    import temp_monitor_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sdaBus,
    output logic      scl,
    output logic      sda
);
    int nNack = 0;

    // Idle bus: both lines released
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // ----------------------------------------------------------------
    // Bit level, 125 ns clock period
    // ----------------------------------------------------------------
    task automatic hc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : hc

    // Data set mid low phase, sampled mid high phase
    task automatic bit_x(input logic b, output logic r);
        hc(6);
        sda = b;
        hc(7);
        scl = 1'b1;
        hc(6);
        r = sdaBus;
        hc(6);
        scl = 1'b0;
    endtask : bit_x

    task automatic start;
        hc(6);
        sda = 1'b1;
        hc(7);
        scl = 1'b1;
        hc(12);
        sda = 1'b0;
        hc(12);
        scl = 1'b0;
    endtask : start

    task automatic stop;
        hc(6);
        sda = 1'b0;
        hc(7);
        scl = 1'b1;
        hc(12);
        sda = 1'b1;
        hc(12);
    endtask : stop

    // ----------------------------------------------------------------
    // Byte level, MSB first
    // ----------------------------------------------------------------
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        if (r) nNack++;
    endtask : tx

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        start();
        tx({DEV_ADDR, 1'b0});
        tx(a);
        tx(d);
        stop();
    endtask : wr

    // Pointer write, repeated start, one byte then not-acknowledge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic r;
        start();
        tx({DEV_ADDR, 1'b0});
        tx(a);
        start();
        tx({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(1'b1, r);
        stop();
    endtask : rd
endmodule : i2c_host_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
    import temp_monitor_pkg::*;
    logic                    ref_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    scl, sdaHost, sdaOut, sdaOe;
    logic                    convDone, convStart, standby;
    logic                    warnOe, critOe;
    logic [2:0]              convCh;
    logic signed [RAW_W-1:0] convRaw;
    logic signed [RAW_W-1:0] raws [5];
    logic [10:0]             e;
    int                      n_errors = 0;
    int                      samples_checked = 0;
    int                      nStart = 0;
    wire                     sdaBus = sdaHost & (sdaOe ? sdaOut : 1'b1);

    temp_result_format_limit_compare temp_result_format_limit_compare_i (
        .ref_clk, .rst, .sclIn(scl), .sdaIn(sdaBus), .sdaOut, .sdaOe,
        .convDone, .convCh, .convRaw, .convStart, .standby, .warnOe,
        .critOe);
    i2c_host_model i2c_host_model_i (.ref_clk, .sdaBus, .scl,
        .sda(sdaHost));

    // ----------------------------------------------------------------
    // Clock, start counter, watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) if (convStart === 1'b1) nStart++;
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [7:0] got,
                         input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i2c_host_model_i.wr(a, d);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] d;
        i2c_host_model_i.rd(a, d);
        check($sformatf("reg %h", a), d, x);
    endtask : rdc

    // One-cycle result pulse, returns once outputs have updated
    task automatic conv(input int ch, input logic [RAW_W-1:0] raw);
        @(posedge ref_clk);
        #1;
        convDone = 1'b1;
        convCh = ch[2:0];
        convRaw = raw;
        @(posedge ref_clk);
        #1;
        convDone = 1'b0;
    endtask : conv

    // Expected code: clamp to the range, offset in extended range
    function automatic logic [10:0] fmt(input int raw, input bit ext);
        int v;
        v = ext ? raw + 512 : raw;
        if (v < 0) v = 0;
        if (v > int'(ext ? CODE_MAX : DEF_MAX)) v = ext ? 2047 : 1023;
        return v[10:0];
    endfunction : fmt

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        convDone = 1'b0;
        convCh = 3'h0;
        convRaw = '0;
        raws = '{12'shda8, 12'shff8, 12'sh0a9, 12'sh3ff, 12'sh7ff};
        repeat (20) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge ref_clk);
        rdc(ADR_CONFIG, RST_CONFIG);
        rdc(ADR_HI_BASE + 8'h04, RST_HI_LIM);
        rdc(ADR_CRIT_BASE + 8'h02, RST_CRIT_LIM);
        rdc(ADR_HYST, RST_HYST);
        rdc(ADR_ONESHOT, 8'h00);
        // High limit is strict, read clears status and summary
        wr(ADR_HI_BASE + 8'h02, 8'h20);
        conv(2, 12'sh100);
        rdc(ADR_HISTAT, 8'h00);
        conv(2, 12'sh101);
        check("warn", {7'h0, warnOe}, 8'h01);
        rdc(ADR_STATUS, 8'h10);
        rdc(ADR_HISTAT, 8'h04);
        rdc(ADR_STATUS, 8'h00);
        rdc(ADR_HISTAT, 8'h00);
        check("warn", {7'h0, warnOe}, 8'h00);
        // Low limit includes equality
        wr(ADR_LO_BASE + 8'h03, 8'h10);
        conv(3, 12'sh081);
        check("warn", {7'h0, warnOe}, 8'h00);
        conv(3, 12'sh080);
        check("warn", {7'h0, warnOe}, 8'h01);
        rdc(ADR_LOSTAT, 8'h08);
        // Aliased addresses
        wr(ADR_HI0_B, 8'h33);
        rdc(ADR_HI0_A, 8'h33);
        rdc(ADR_HI_BASE, 8'h33);
        wr(ADR_LO_BASE, 8'h05);
        rdc(ADR_LO0_B, 8'h05);
        rdc(ADR_LO0_A, 8'h05);
        wr(ADR_CONFIG_ALT, 8'h80);
        rdc(ADR_CONFIG, 8'h80);
        // Masked warning, critical still asserts
        conv(1, 12'sh300);
        check("warn", {7'h0, warnOe}, 8'h00);
        rdc(ADR_HISTAT, 8'h02);
        conv(4, 12'sh320);
        check("crit", {7'h0, critOe}, 8'h01);
        rdc(ADR_CRITSTAT, 8'h10);
        rdc(ADR_STATUS, 8'h12);
        conv(4, 12'sh2d0);
        check("crit", {7'h0, critOe}, 8'h01);
        conv(4, 12'sh2cf);
        check("crit", {7'h0, critOe}, 8'h00);
        // Channel codes past the last channel are ignored
        conv(5, 12'sh7ff);
        check("crit", {7'h0, critOe}, 8'h00);
        rdc(ADR_HISTAT, 8'h10);
        // Standby: limit acts only after a conversion
        wr(ADR_CONFIG, 8'h40);
        check("standby", {7'h0, standby}, 8'h01);
        wr(ADR_CRIT_BASE + 8'h04, 8'h10);
        check("crit", {7'h0, critOe}, 8'h00);
        wr(ADR_ONESHOT, 8'h00);
        check("starts", 8'(nStart), 8'h01);
        conv(4, 12'sh2cf);
        check("crit", {7'h0, critOe}, 8'h01);
        wr(ADR_CONFIG, 8'h00);
        check("starts", 8'(nStart), 8'h02);
        wr(ADR_CRIT_BASE + 8'h04, RST_CRIT_LIM);
        conv(4, 12'sh100);
        check("crit", {7'h0, critOe}, 8'h00);
        // Result format in both ranges, every channel
        for (int x = 0; x < 2; x++) begin
            wr(ADR_CONFIG, (x == 1) ? 8'h04 : 8'h00);
            for (int i = 0; i < NCH; i++) begin
                conv(i, raws[i]);
                e = fmt(int'(raws[i]), x == 1);
                rdc(ADR_TEMP_BASE + 8'(2 * i), e[10:3]);
                rdc(ADR_TEMP_BASE + 8'(2 * i + 1), {e[2:0], 5'h0});
            end
        end
        // Extended range: limit written in offset encoding, 40 degrees
        wr(ADR_HI_BASE + 8'h01, 8'h68);
        conv(1, 12'sh140);
        rdc(ADR_HISTAT, 8'h1c);
        conv(1, 12'sh148);
        rdc(ADR_HISTAT, 8'h02);
        check("nack", 8'(i2c_host_model_i.nNack), 8'h00);
        finish_test();
    end
endmodule : tb
